// ### bench/carrier_detect_frame_sync_tb.sv
`default_nettype none
module carrier_detect_frame_sync_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int QC = 20;
	localparam int WC = 100;
	localparam int DC = 80;
	logic ref_clk, nrst, lvl, th, tv, txd, dsel, rdy, feed, wdog, sync;
	logic cd_n, rxd, rxv, rxc, rxb, txm, cts, rst_o, ovf, ov_seen;
	logic [31:0] seed;
	logic [2:0] hist;
	int num_errors, checked, tcount, n;
	carrier_detect_frame_sync #(.QUALIFY_CYC(QC), .WDOG_CYC(WC), .DIR_CYC(DC)) u_carrier_detect_frame_sync (
		.ref_clk_i(ref_clk), .nrst_i(nrst), .level_above_i(lvl), .tone_high_i(th), .tone_valid_i(tv),
		.txd_i(txd), .direction_select_i(dsel), .watchdog_i(wdog), .rx_ready_i(rdy),
		.carrier_detect_n_o(cd_n), .rxd_o(rxd), .rx_valid_o(rxv), .rx_carrier_o(rxc), .rx_bit_o(rxb),
		.tx_mode_o(txm), .cts_o(cts), .reset_o(rst_o), .overflow_o(ovf));
	host_model u_host_model (.ref_clk_i(ref_clk), .nrst_i(nrst), .feed_i(feed), .rxd_i(rxd),
		.watchdog_o(wdog), .sync_o(sync));
	// ----------------------------------------------------------------
	// Clock, watchdog of the run, helpers
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = !ref_clk;
	end
	// A hang counts as a mismatch and still reaches the verdict
	always @(posedge ref_clk) begin
		tcount++;
		// Flag cleared while reset is held, set by any drop pulse
		if (ovf === 1'b1) ov_seen = 1'b1;
		else if (nrst !== 1'b1) ov_seen = 1'b0;
		if (tcount == 5000) begin
			num_errors++;
			complete_run();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Clamped output idles high, otherwise the tone two edges back
	function automatic logic exp_rxd(input logic clamp, input logic tone);
		return clamp ? 1'b1 : tone;
	endfunction
	task chk(input string nm, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %b seen %b", nm, exp, got);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask
	// Counts falling edges until the carrier flag reaches a level
	task wait_cd(input logic want, output int k);
		k = 0;
		while (cd_n !== want && k < QC + 10) begin
			@(negedge ref_clk);
			k++;
		end
	endtask
	task complete_run();
		if (num_errors == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{nrst, lvl, th, tv} = 4'h0;
		{txd, dsel, rdy, feed} = 4'hf;
		seed = 32'h00000039;
		hist = 3'h0;
		cyc(16);
		nrst <= 1'b1;
		@(negedge ref_clk);
		chk("cd_n_reset", 1'b1, cd_n);
		chk("rxd_reset", 1'b1, rxd);
		// Dip near the end of qualifying must restart the count
		@(posedge ref_clk) lvl <= 1'b1;
		cyc(QC - 4);
		lvl <= 1'b0;
		cyc(1);
		lvl <= 1'b1;
		wait_cd(1'b0, n);
		chk("qualify_time", 1'b1, n >= QC);
		chk("cd_n_on", 1'b0, cd_n);
		// Short loss inside hold keeps the carrier
		@(posedge ref_clk) lvl <= 1'b0;
		cyc(QC / 2);
		lvl <= 1'b1;
		cyc(QC);
		@(negedge ref_clk) chk("cd_n_resume", 1'b0, cd_n);
		// Passed, clamped and unclamped data with random tones
		for (int m = 0; m < 3; m++) begin
			if (m == 1) begin
				@(posedge ref_clk) lvl <= 1'b0;
				wait_cd(1'b1, n);
				chk("hold_time", 1'b1, n >= QC);
				chk("cd_n_off", 1'b1, cd_n);
			end
			for (int i = 0; i < 40; i++) begin
				@(posedge ref_clk);
				seed = xs(seed);
				th <= seed[0];
				tv <= 1'b1;
				txd <= (m != 2);
				hist = {hist[1:0], seed[0]};
				@(negedge ref_clk);
				if (i > 3) chk("rxd_data", exp_rxd(m == 1, hist[2]), rxd);
			end
		end
		// Fill the buffer while the drain stalls, then empty it
		@(posedge ref_clk) th <= 1'b0;
		cyc(6);
		rdy <= 1'b0;
		for (int i = 0; i < 24; i++) begin
			@(posedge ref_clk) th <= !i[0];
			cyc(1);
		end
		cyc(3);
		@(negedge ref_clk);
		chk("overflow", 1'b1, ov_seen);
		chk("rx_valid_full", 1'b1, rxv);
		chk("rx_bit_head", 1'b1, rxb);
		chk("rx_carrier_head", 1'b0, rxc);
		@(posedge ref_clk) rdy <= 1'b1;
		cyc(40);
		rdy <= 1'b0;
		cyc(3);
		@(negedge ref_clk) chk("rx_valid_empty", 1'b0, rxv);
		// Frame sync: long high run of data, then a start bit
		@(posedge ref_clk) th <= 1'b1;
		cyc(50);
		@(negedge ref_clk) chk("no_early_sync", 1'b0, sync);
		@(posedge ref_clk) th <= 1'b0;
		cyc(4);
		@(negedge ref_clk) chk("frame_sync", 1'b1, sync);
		// Transmit selection and its forced return; channel looked at first
		chk("channel_free", 1'b1, cd_n);
		@(posedge ref_clk) dsel <= 1'b0;
		cyc(2);
		@(negedge ref_clk);
		chk("tx_mode_on", 1'b1, txm);
		chk("cts_low", 1'b0, cts);
		cyc(DC + 6);
		@(negedge ref_clk) chk("tx_mode_limit", 1'b0, txm);
		@(posedge ref_clk) dsel <= 1'b1;
		cyc(2);
		@(negedge ref_clk) chk("cts_high", 1'b1, cts);
		// Watchdog starved, then fed again
		chk("reset_fed", 1'b0, rst_o);
		@(posedge ref_clk) feed <= 1'b0;
		cyc(WC + 8);
		@(negedge ref_clk) chk("reset_starved", 1'b1, rst_o);
		@(posedge ref_clk) feed <= 1'b1;
		cyc(50);
		@(negedge ref_clk) chk("reset_cleared", 1'b0, rst_o);
		complete_run();
	end
endmodule
`default_nettype wire

// ### bench/cdfs_sva.sv
`default_nettype none
module cdfs_sva #(
	parameter int unsigned QUALIFY_CYC = 20,
	parameter int unsigned WDOG_CYC    = 100,
	parameter int unsigned DIR_CYC     = 80
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic level_above_i,
	input wire logic tone_high_i,
	input wire logic tone_valid_i,
	input wire logic txd_i,
	input wire logic direction_select_i,
	input wire logic watchdog_i,
	input wire logic carrier_detect_n_o,
	input wire logic rxd_o,
	input wire logic tx_mode_o,
	input wire logic cts_o,
	input wire logic reset_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Run-length counters
	// ----------------------------------------------------------------
	int unsigned hi_cnt;  // Edges with level above, unbroken
	int unsigned lo_cnt;  // Edges with level below, unbroken
	int unsigned dl_cnt;  // Edges with transmit selected, unbroken
	int unsigned wd_cnt;  // Edges since last watchdog fall
	logic        wd_prev; // Watchdog level at previous edge
	// Counters restart on any break, so a dip cannot be hidden
	always_ff @(posedge ref_clk_i) begin
		hi_cnt  <= (!nrst_i || !level_above_i) ? 0 : hi_cnt + 1;
		lo_cnt  <= (!nrst_i || level_above_i) ? 0 : lo_cnt + 1;
		dl_cnt  <= (!nrst_i || direction_select_i) ? 0 : dl_cnt + 1;
		wd_cnt  <= (!nrst_i || (wd_prev && !watchdog_i)) ? 0 : wd_cnt + 1;
		wd_prev <= watchdog_i;
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	// ----------------------------------------------------------------
	// Properties; slack of a few edges covers input registering
	// ----------------------------------------------------------------
	// Run length one edge back: a dip on the very edge of the fall must not hide a full qualify
	cd_fall_a: assert property ($fell(carrier_detect_n_o) |-> $past(hi_cnt) >= QUALIFY_CYC) else $error("early carrier");
	cd_on_a: assert property (hi_cnt > QUALIFY_CYC + 4 |-> !carrier_detect_n_o) else $error("carrier missed");
	cd_hold_a: assert property ($rose(carrier_detect_n_o) |-> $past(lo_cnt) >= QUALIFY_CYC) else $error("short hold");
	cd_off_a: assert property (lo_cnt > QUALIFY_CYC + 4 |-> carrier_detect_n_o) else $error("carrier stuck");
	rx_clamp_a: assert property ((direction_select_i && txd_i && carrier_detect_n_o) [*3] |-> rxd_o)
		else $error("data not clamped");
	rx_open_a: assert property ((direction_select_i && !txd_i && tone_valid_i) [*3] |-> rxd_o == $past(tone_high_i, 2))
		else $error("data not passed");
	cts_loop_a: assert property (nrst_i |=> cts_o == $past(direction_select_i)) else $error("cts not looped");
	tx_on_a: assert property (dl_cnt inside {[1:DIR_CYC - 3]} |-> tx_mode_o) else $error("no transmit");
	tx_off_a: assert property (dl_cnt == 0 || dl_cnt > DIR_CYC + 3 |-> !tx_mode_o) else $error("transmit held");
	wd_trip_a: assert property (wd_cnt > WDOG_CYC + 4 |-> reset_o) else $error("no watchdog reset");
	wd_calm_a: assert property (wd_cnt inside {[4:WDOG_CYC - 4]} |-> !reset_o) else $error("early reset");
endmodule
bind carrier_detect_frame_sync cdfs_sva #(.QUALIFY_CYC(QUALIFY_CYC), .WDOG_CYC(WDOG_CYC), .DIR_CYC(DIR_CYC)) u_cdfs_sva (
	.ref_clk_i, .nrst_i, .level_above_i, .tone_high_i, .tone_valid_i, .txd_i, .direction_select_i, .watchdog_i,
	.carrier_detect_n_o, .rxd_o, .tx_mode_o, .cts_o, .reset_o);
`default_nettype wire

// ### bench/host_model.sv
`default_nettype none
module host_model #(
	parameter int WD_PER   = 40,
	parameter int SYNC_CYC = 35
) (
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	input  wire logic feed_i,
	input  wire logic rxd_i,
	output logic      watchdog_o,
	output logic      sync_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Ready answer is the host's own ready looped back outside; ring not wired
	int wd_reg; // Watchdog period phase
	int hi_reg; // Unbroken high time of received data
	// Watchdog stands still when feeding stops, so no edge at all
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || !feed_i || wd_reg == WD_PER - 1) wd_reg <= 0;
		else wd_reg <= wd_reg + 1;
	end
	assign watchdog_o = !(feed_i && wd_reg < 4);
	// High time restarts on every low bit; noise rarely stays high
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || !rxd_i) hi_reg <= 0;
		else if (hi_reg < SYNC_CYC) hi_reg <= hi_reg + 1;
	end
	// Frame entered on the start bit after a long enough high run
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) sync_o <= 1'b0;
		else if (!rxd_i && hi_reg == SYNC_CYC) sync_o <= 1'b1;
		// A long idle high run ends the frame; hunting starts again
		else if (rxd_i && hi_reg == SYNC_CYC) sync_o <= 1'b0;
	end
endmodule
`default_nettype wire

// ### rtl/carrier_detect_frame_sync.sv
// Functional notes
// - Carrier qualified after level held qualify time
// - Hold carrier flag qualify time after loss
// - Upper tone gives one, lower gives zero
// - Clamp received data while no carrier
// - Transmit data low removes the clamp in receive mode only
// - Unclamped noise data is not framed
// - First three bits after carrier qualified are not buffered unless transmit data is low
// - Zero transmits; auto receive after 1s
// - Reset output high after 1.5s silence
`default_nettype none
module carrier_detect_frame_sync #(
	parameter int unsigned QUALIFY_CYC = cdfs_pkg::QUALIFY_CYC,
	parameter int unsigned WDOG_CYC    = cdfs_pkg::WDOG_CYC,
	parameter int unsigned DIR_CYC     = cdfs_pkg::DIR_CYC
) (
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	input  wire logic level_above_i,      // Receive level above detect threshold
	input  wire logic tone_high_i,        // Discriminator: upper tone seen
	input  wire logic tone_valid_i,       // Discriminator output meaningful
	input  wire logic txd_i,              // Host transmit data
	input  wire logic direction_select_i, // 0 transmit, 1 receive
	input  wire logic watchdog_i,         // Host watchdog clock
	input  wire logic rx_ready_i,         // Drain side may take a bit
	output logic      carrier_detect_n_o, // Low while carrier qualified
	output logic      rxd_o,              // Received data to host
	output logic      rx_valid_o,         // Buffered bit available while drain side not ready
	output logic      rx_carrier_o,       // Carrier flag of buffered bit
	output logic      rx_bit_o,           // Buffered bit
	output logic      tx_mode_o,          // High in transmit mode
	output logic      cts_o,              // Direction select looped back to host
	output logic      reset_o,            // Watchdog reset, active high
	output logic      overflow_o          // Sample lost to full buffer
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	cdfs_pkg::cd_state_type cd_state_reg;     // Carrier detect state
	logic [cdfs_pkg::CNT_W-1:0] qual_cnt_reg; // Qualify and hold timer
	logic [cdfs_pkg::CNT_W-1:0] wd_cnt_reg;   // Watchdog silence timer
	logic [cdfs_pkg::CNT_W-1:0] dir_cnt_reg;  // Transmit hold timer
	logic [1:0] drop_cnt_reg;                 // Bits still to discard
	logic       demod_reg;                    // Last demodulated bit
	logic       demod_prev_reg;               // For bit edge detection
	logic       wd_prev_reg;                  // Watchdog previous level
	logic       clamp_off;                    // Clamp removed
	logic       rx_mode;                      // Receive mode active
	logic       bit_edge;                     // New bit boundary
	cdfs_pkg::rx_word_type fifo_in;           // Word into buffer
	cdfs_pkg::rx_word_type fifo_out;          // Word out of buffer
	logic       fifo_in_ready;                // Buffer can accept
	logic       fifo_out_valid;               // Buffer has a word
	logic       push;                         // Sample offered

	// Timer helper, used by every timeout
	function automatic logic reached(input logic [cdfs_pkg::CNT_W-1:0] cnt, input int unsigned lim);
		reached = (cnt >= cdfs_pkg::CNT_W'(lim - 1));
	endfunction

	// ----------------------------------------------------------------
	// Carrier qualification
	// ----------------------------------------------------------------
	// Both the qualify and the hold phase use the same timer
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			cd_state_reg <= cdfs_pkg::CD_IDLE;
			qual_cnt_reg <= '0;
		end else begin
			unique case (cd_state_reg)
				cdfs_pkg::CD_IDLE: begin
					qual_cnt_reg <= '0;
					if (level_above_i) begin
						cd_state_reg <= cdfs_pkg::CD_QUALIFY;
					end
				end
				cdfs_pkg::CD_QUALIFY: begin
					// A dip restarts qualification
					if (!level_above_i) begin
						cd_state_reg <= cdfs_pkg::CD_IDLE;
					end else if (reached(qual_cnt_reg, QUALIFY_CYC)) begin
						cd_state_reg <= cdfs_pkg::CD_ACTIVE;
						qual_cnt_reg <= '0;
					end else begin
						qual_cnt_reg <= cdfs_pkg::CNT_W'(qual_cnt_reg + 1'b1);
					end
				end
				cdfs_pkg::CD_ACTIVE: begin
					qual_cnt_reg <= '0;
					if (!level_above_i) begin
						cd_state_reg <= cdfs_pkg::CD_HOLD;
					end
				end
				cdfs_pkg::CD_HOLD: begin
					// Returning signal resumes the active state
					if (level_above_i) begin
						cd_state_reg <= cdfs_pkg::CD_ACTIVE;
					end else if (reached(qual_cnt_reg, QUALIFY_CYC)) begin
						cd_state_reg <= cdfs_pkg::CD_IDLE;
					end else begin
						qual_cnt_reg <= cdfs_pkg::CNT_W'(qual_cnt_reg + 1'b1);
					end
				end
			endcase
		end
	end

	// Carrier output, low in active and hold states
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			carrier_detect_n_o <= 1'b1;
		end else begin
			carrier_detect_n_o <= !(cd_state_reg == cdfs_pkg::CD_ACTIVE || cd_state_reg == cdfs_pkg::CD_HOLD);
		end
	end

	// ----------------------------------------------------------------
	// Demodulated data and clamp
	// ----------------------------------------------------------------
	// Upper tone maps to one; keep last bit when output meaningless
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			demod_reg      <= 1'b1;
			demod_prev_reg <= 1'b1;
		end else begin
			if (tone_valid_i) begin
				demod_reg <= tone_high_i;
			end
			demod_prev_reg <= demod_reg;
		end
	end

	assign rx_mode   = !tx_mode_o;
	assign clamp_off = rx_mode && !txd_i;
	assign bit_edge  = demod_reg != demod_prev_reg;

	// Discard the first bits after a new carrier; training eats them
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			drop_cnt_reg <= 2'(cdfs_pkg::DROP_BITS);
		end else if (carrier_detect_n_o) begin
			drop_cnt_reg <= 2'(cdfs_pkg::DROP_BITS);
		end else if (bit_edge && drop_cnt_reg != '0) begin
			drop_cnt_reg <= 2'(drop_cnt_reg - 1'b1);
		end
	end

	// Clamped output idles high like a stop bit; unclamped noise
	// passes as is, so framing is the host's job
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			rxd_o <= 1'b1;
		end else if (clamp_off) begin
			rxd_o <= demod_reg;
		end else if (carrier_detect_n_o || !rx_mode) begin
			rxd_o <= 1'b1;
		end else begin
			rxd_o <= demod_reg;
		end
	end

	// ----------------------------------------------------------------
	// Sample buffer
	// ----------------------------------------------------------------
	// Bits are buffered at edges once the training bits are gone
	assign push            = bit_edge && rx_mode && (clamp_off || (!carrier_detect_n_o && drop_cnt_reg == '0));
	assign fifo_in.carrier = !carrier_detect_n_o;
	assign fifo_in.data    = demod_reg;

	sample_fifo #(
		.WIDTH(cdfs_pkg::FIFO_W),
		.DEPTH(cdfs_pkg::FIFO_D)
	) u_fifo (
		.ref_clk_i  (ref_clk_i),
		.nrst_i     (nrst_i),
		.in_data_i  (fifo_in),
		.in_valid_i (push),
		.in_ready_o (fifo_in_ready),
		.out_data_o (fifo_out),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(rx_ready_i)
	);

	// Drain side outputs; a full buffer drops and flags the sample
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			rx_valid_o   <= 1'b0;
			rx_bit_o     <= 1'b0;
			rx_carrier_o <= 1'b0;
			overflow_o   <= 1'b0;
		end else begin
			rx_valid_o   <= fifo_out_valid && !rx_ready_i;
			rx_bit_o     <= fifo_out.data;
			rx_carrier_o <= fifo_out.carrier;
			overflow_o   <= push && !fifo_in_ready;
		end
	end

	// ----------------------------------------------------------------
	// Direction control
	// ----------------------------------------------------------------
	// Transmit held too long falls back to receive until released
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			dir_cnt_reg <= '0;
			tx_mode_o   <= 1'b0;
			cts_o       <= 1'b1;
		end else begin
			cts_o <= direction_select_i;
			if (direction_select_i) begin
				dir_cnt_reg <= '0;
				tx_mode_o   <= 1'b0;
			end else if (reached(dir_cnt_reg, DIR_CYC)) begin
				tx_mode_o <= 1'b0;
			end else begin
				dir_cnt_reg <= cdfs_pkg::CNT_W'(dir_cnt_reg + 1'b1);
				tx_mode_o   <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	// Only falling edges feed the dog; reset stays high until one comes
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			wd_prev_reg <= 1'b1;
			wd_cnt_reg  <= '0;
			reset_o     <= 1'b0;
		end else begin
			wd_prev_reg <= watchdog_i;
			if (wd_prev_reg && !watchdog_i) begin
				wd_cnt_reg <= '0;
				reset_o    <= 1'b0;
			end else if (reached(wd_cnt_reg, WDOG_CYC)) begin
				reset_o <= 1'b1;
			end else begin
				wd_cnt_reg <= cdfs_pkg::CNT_W'(wd_cnt_reg + 1'b1);
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/cdfs_pkg.sv
`default_nettype none
package cdfs_pkg;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ         = 125;           // Clock rate in MHz
	localparam int unsigned QUALIFY_US      = 4000;          // Detect qualify time in us
	localparam int unsigned WDOG_TIMEOUT_MS = 1500;          // Watchdog timeout in ms
	localparam int unsigned DIR_TIMEOUT_MS  = 1000;          // Transmit hold limit in ms
	localparam int unsigned QUALIFY_CYC     = QUALIFY_US * CLK_MHZ;              // Least time, rounds up exactly
	localparam int unsigned WDOG_CYC        = WDOG_TIMEOUT_MS * 1000 * CLK_MHZ;  // Longest time
	localparam int unsigned DIR_CYC         = DIR_TIMEOUT_MS * 1000 * CLK_MHZ;   // Longest time
	localparam int unsigned CNT_W           = 28;            // Wide enough for all counts
	localparam int unsigned DROP_BITS       = 3;             // Bits lost at start of carrier
	localparam int unsigned FIFO_W          = 2;             // Data plus carrier flag
	localparam int unsigned FIFO_D          = 16;            // Buffer depth in words

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CD_IDLE    = 2'b00,
		CD_QUALIFY = 2'b01,
		CD_ACTIVE  = 2'b11,
		CD_HOLD    = 2'b10
	} cd_state_type;

	typedef struct packed {
		logic carrier;   // Carrier was qualified when sampled
		logic data;      // Demodulated bit
	} rx_word_type;
endpackage
`default_nettype wire

// ### rtl/sample_fifo.sv
`default_nettype none
// Small synchronous FIFO; read data comes from a register
module sample_fifo #(
	parameter int unsigned WIDTH = 2,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             ref_clk_i,
	input  wire logic             nrst_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];   // Storage
	logic [AW-1:0]    wr_ptr_reg;        // Write pointer
	logic [AW-1:0]    rd_ptr_reg;        // Read pointer
	logic [AW:0]      count_reg;         // Words held in storage
	logic             push;              // Accepted write
	logic             pop;               // Move word to output register

	// ----------------------------------------------------------------
	// Handshake terms
	// ----------------------------------------------------------------
	assign push = in_valid_i && in_ready_o;
	// Refill output register when empty or being taken
	assign pop  = (count_reg != '0) && (!out_valid_o || out_ready_i);

	// Storage write
	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	// Pointers and count
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
			end
			if (pop) begin
				rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
			end
			count_reg <= (AW+1)'(count_reg + (AW+1)'(push) - (AW+1)'(pop));
		end
	end

	// Honest full: ready only with room left after this cycle
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			in_ready_o <= 1'b0;
		end else begin
			in_ready_o <= ((AW+1)'(count_reg + (AW+1)'(push) - (AW+1)'(pop)) < (AW+1)'(DEPTH - 1));
		end
	end

	// Registered output stage
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
		end else if (pop) begin
			out_valid_o <= 1'b1;
			out_data_o  <= mem_reg[rd_ptr_reg];
		end else if (out_ready_i) begin
			out_valid_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire
